// ---- design/ccs_params.svh ----
// Constants for the common command and status unit
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// Event register bit positions
`define CCS_EV_OPC        0
`define CCS_EV_QYE        2
`define CCS_EV_DDE        3
`define CCS_EV_EXE        4
`define CCS_EV_CME        5
`define CCS_EV_PON        7
// Bits that exist in event register and its mask
`define CCS_EV_USED       8'hBD
// Power-on value of the event register
`define CCS_ESR_RST       8'h80
// Status byte bit positions
`define CCS_SB_ESB        5
`define CCS_SB_RQS        6
`define CCS_SB_OWN        8'h60
// Recall slots
`define CCS_SLOT_MAX      8'h09
`define CCS_SLOTS         10
// Reply text
`define CCS_ASCII_0       8'h30
`define CCS_ONE           8'h01
`define CCS_DEC_HUND      8'h64
`define CCS_DEC_TEN       8'h0A
`define CCS_IDN_LEN       6'h2C
`define CCS_IDN_LAST      6'h2B
`define CCS_NUM_LAST      2'h2

`endif

// ---- design/ccs_pkg.sv ----
// Types shared by the common command and status unit
package ccs_pkg;
    // Decoded common commands and queries
    typedef enum logic [3:0] {
        ccs_cmd_cls, ccs_cmd_ese, ccs_cmd_ese_q, ccs_cmd_esr_q,
        ccs_cmd_idn_q, ccs_cmd_opc, ccs_cmd_opc_q, ccs_cmd_psc,
        ccs_cmd_psc_q, ccs_cmd_rcl, ccs_cmd_rst, ccs_cmd_sre,
        ccs_cmd_sre_q, ccs_cmd_stb_q
    } ccs_cmd_t;
    // Reply sequencer states
    typedef enum logic [1:0] {
        ccs_r_idle, ccs_r_wait_opc, ccs_r_load, ccs_r_send
    } ccs_reply_st_t;
endpackage

// ---- design/ccs_slot_mem.sv ----
// Saved-state slot memory with written flags and registered read
`timescale 1ns/1ps
`default_nettype none
module ccs_slot_mem #(
    parameter int DEPTH = 10,
    parameter int W     = 32
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         wr_en,
    input  wire logic [3:0]   wr_addr,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rd_en,
    input  wire logic [3:0]   rd_addr,
    output logic      [W-1:0] rd_data,
    output logic              rd_written
);
    logic [W-1:0]     mem [DEPTH];
    logic [DEPTH-1:0] written;

    // Storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Slots start empty; a save marks the slot
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            written    <= '0;
            rd_data    <= '0;
            rd_written <= 1'b0;
        end else begin
            if (wr_en) begin
                written[wr_addr] <= 1'b1;
            end
            if (rd_en) begin
                rd_data    <= mem[rd_addr];
                rd_written <= written[rd_addr];
            end
        end
    end
endmodule // ccs_slot_mem
`default_nettype wire

// ---- design/ccs_unit.sv ----
// Common command decoder, standard event status and reply sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"

// Overview of operation
// - Clear-status zeroes event register, service request and outside event registers.
// - Event mask selects which event bits drive the status byte summary bit.
// - Mask query replies with the mask as decimal ASCII text.
// - Bit 0 flags completion of all work up to an operation-complete command.
// - Bit 2 flags query faults, including a new command during a pending reply.
// - Bit 3 flags self-test failure or calibration error.
// - Bit 4 flags any command failing during execution.
// - Bit 5 flags command syntax errors.
// - Bit 7 is set by power-up until read or cleared.
// - Event query replies with the flags as decimal ASCII text.
// - Identity reply has maker, model, serial, revision separated by commas.
// - Revision holds three dotted groups joined by hyphens.
// - Operation-complete command sets bit 0 only after it has executed.
// - Operation-complete query replies 1 once execution reaches it.
// - Stored power-on-clear setting clears or keeps both masks at power-up.
// - Recall accepts slot 0 to 9 and restores the saved state.
// - Recall of an empty slot loads reset defaults.
// - Reset loads defaults, leaving status registers and errors untouched.
// - Reset also aborts triggers and clears waiting-for-trigger bits.
// - Status byte query does not clear the request-service bit.
module ccs_unit #(
    parameter int               STATE_W    = 32,
    parameter logic [STATE_W-1:0] DEFAULT_STATE = '0,
    parameter logic [63:0]      MAKER_STR  = "ACMELABS", // Arbitrary value
    parameter logic [63:0]      MODEL_STR  = "PSU-0002", // Arbitrary value
    parameter logic [63:0]      SERIAL_STR = "SN000001"  // Arbitrary value
) (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               cmd_valid,
    input  wire ccs_pkg::ccs_cmd_t  cmd_code,
    input  wire logic [7:0]         cmd_arg,
    input  wire logic               exec_idle,
    input  wire logic               query_fault_evt,
    input  wire logic               self_test_fail_evt,
    input  wire logic               cal_error_evt,
    input  wire logic               exec_fault_evt,
    input  wire logic               syntax_fault_evt,
    input  wire logic               serial_poll,
    input  wire logic [7:0]         stb_other,
    input  wire logic               nv_psc,
    input  wire logic [7:0]         nv_ese,
    input  wire logic [7:0]         nv_sre,
    input  wire logic [11:0]        ctl_rev,
    input  wire logic [11:0]        fp_rev,
    input  wire logic [11:0]        mb_rev,
    input  wire logic               save_valid,
    input  wire logic [3:0]         save_slot,
    input  wire logic [STATE_W-1:0] save_state,
    input  wire logic               reply_ready,
    output logic                    reply_valid,
    output logic [7:0]              reply_data,
    output logic                    reply_last,
    output logic [7:0]              standard_event_flags,
    output logic [7:0]              standard_event_enable_mask,
    output logic [7:0]              status_enable_mask,
    output logic [7:0]              status_byte,
    output logic                    psc_setting,
    output logic                    clear_events,
    output logic                    restore_valid,
    output logic [STATE_W-1:0]      restore_state,
    output logic                    restore_default,
    output logic                    defaults_load,
    output logic                    trigger_abort,
    output logic                    waiting_for_trigger_clear
);
    ccs_pkg::ccs_reply_st_t state;
    logic               init_done;
    logic               opc_pending;
    logic               svc_prev;
    logic               rcl_wait;
    logic               is_idn;
    logic [7:0]         num_reg;
    logic [5:0]         idx;
    logic [STATE_W-1:0] mem_data;
    logic               mem_written;

    // Decimal text of a byte, left aligned, no leading zeros
    function automatic logic [23:0] dec_str(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] u;
        h = v / `CCS_DEC_HUND;
        t = (v / `CCS_DEC_TEN) % `CCS_DEC_TEN;
        u = v % `CCS_DEC_TEN;
        if (v >= `CCS_DEC_HUND) begin
            dec_str = {h + `CCS_ASCII_0, t + `CCS_ASCII_0, u + `CCS_ASCII_0};
        end else if (v >= `CCS_DEC_TEN) begin
            dec_str = {t + `CCS_ASCII_0, u + `CCS_ASCII_0, 8'h00};
        end else begin
            dec_str = {u + `CCS_ASCII_0, 16'h0000};
        end
    endfunction

    // Number of decimal digits of a byte
    function automatic logic [1:0] dec_len(input logic [7:0] v);
        dec_len = (v >= `CCS_DEC_HUND) ? 2'h3 : (v >= `CCS_DEC_TEN) ? 2'h2 : 2'h1;
    endfunction

    // One dotted version group from three digit nibbles
    function automatic logic [39:0] ver_str(input logic [11:0] r);
        ver_str = {4'h3, r[11:8], ".", 4'h3, r[7:4], ".", 4'h3, r[3:0]};
    endfunction

    // Command decode
    wire take    = cmd_valid && init_done;
    wire do_cls  = take && cmd_code == ccs_pkg::ccs_cmd_cls;
    wire do_ese  = take && cmd_code == ccs_pkg::ccs_cmd_ese;
    wire do_esrq = take && cmd_code == ccs_pkg::ccs_cmd_esr_q;
    wire do_opc  = take && cmd_code == ccs_pkg::ccs_cmd_opc;
    wire do_opcq = take && cmd_code == ccs_pkg::ccs_cmd_opc_q;
    wire do_idnq = take && cmd_code == ccs_pkg::ccs_cmd_idn_q;
    wire do_psc  = take && cmd_code == ccs_pkg::ccs_cmd_psc;
    wire do_rcl  = take && cmd_code == ccs_pkg::ccs_cmd_rcl;
    wire do_rst  = take && cmd_code == ccs_pkg::ccs_cmd_rst;
    wire do_sre  = take && cmd_code == ccs_pkg::ccs_cmd_sre;
    wire do_num  = take && (cmd_code == ccs_pkg::ccs_cmd_ese_q ||
                   cmd_code == ccs_pkg::ccs_cmd_esr_q || cmd_code == ccs_pkg::ccs_cmd_psc_q ||
                   cmd_code == ccs_pkg::ccs_cmd_sre_q || cmd_code == ccs_pkg::ccs_cmd_stb_q);
    wire psc_ok  = cmd_arg <= `CCS_ONE;
    wire slot_ok = cmd_arg <= `CCS_SLOT_MAX;

    // Event sources; a set in the clearing cycle survives the clear
    wire opc_fire = opc_pending && exec_idle;
    wire qye_set  = query_fault_evt || (take && state != ccs_pkg::ccs_r_idle);
    wire dde_set  = self_test_fail_evt || cal_error_evt;
    wire exe_set  = exec_fault_evt || (do_rcl && !slot_ok) || (do_psc && !psc_ok);
    wire [7:0] ev_set = {2'b00, syntax_fault_evt, exe_set, dde_set, qye_set,
                         1'b0, opc_fire} & `CCS_EV_USED;
    wire       esr_clr  = do_cls || do_esrq;
    wire [7:0] next_esr = (standard_event_flags & ~{8{esr_clr}}) | ev_set;

    // Masks: power-on-clear choice at startup, then command writes
    wire [7:0] next_ese = !init_done ? (nv_psc ? 8'h00 : nv_ese & `CCS_EV_USED) :
                          do_ese ? cmd_arg & `CCS_EV_USED : standard_event_enable_mask;
    wire [7:0] sre_used = ~(`CCS_ONE << `CCS_SB_RQS);                         // Service bit not maskable
    wire [7:0] next_sre = !init_done ? (nv_psc ? 8'h00 : nv_sre & sre_used) :
                          do_sre ? cmd_arg & sre_used : status_enable_mask;

    // Status byte summary and request service
    wire       esb      = |(next_esr & next_ese);
    wire [7:0] sb_base  = (stb_other & ~`CCS_SB_OWN) | {2'b00, esb, 5'b00000};
    wire       svc      = |(sb_base & next_sre);
    wire       next_rqs = (svc && !svc_prev) ||
                          (status_byte[`CCS_SB_RQS] && !serial_poll && !do_cls);

    // Reply text sources
    wire [351:0] idn_str = {MAKER_STR, ",", MODEL_STR, ",", SERIAL_STR, ",",
                            ver_str(ctl_rev), "-", ver_str(fp_rev), "-",
                            ver_str(mb_rev)};
    wire [23:0]  num_str = dec_str(num_reg);
    wire [5:0]   pick_idx = (state == ccs_pkg::ccs_r_load) ? 6'h00 : idx + 6'h01;
    wire [8:0]   idn_pos  = {`CCS_IDN_LAST - pick_idx, 3'b000};
    wire [4:0]   num_pos  = {`CCS_NUM_LAST - pick_idx[1:0], 3'b000};
    wire [7:0]   pick_byte = is_idn ? idn_str[idn_pos +: 8] : num_str[num_pos +: 8];
    wire [5:0]   reply_len = is_idn ? `CCS_IDN_LEN : {4'h0, dec_len(num_reg)};
    wire         pick_last = (pick_idx + 6'h01) == reply_len;

    // Value captured for a numeric query, before any clear
    wire [7:0] q_num =
        (cmd_code == ccs_pkg::ccs_cmd_ese_q) ? standard_event_enable_mask :
        (cmd_code == ccs_pkg::ccs_cmd_esr_q) ? standard_event_flags :
        (cmd_code == ccs_pkg::ccs_cmd_psc_q) ? {7'h00, psc_setting} :
        (cmd_code == ccs_pkg::ccs_cmd_sre_q) ? status_enable_mask :
        (cmd_code == ccs_pkg::ccs_cmd_stb_q) ? status_byte : `CCS_ONE;

    // Status registers; power-up leaves the power-cycle bit set
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            standard_event_flags       <= `CCS_ESR_RST;
            standard_event_enable_mask <= 8'h00;
            status_enable_mask         <= 8'h00;
            status_byte                <= 8'h00;
            svc_prev                   <= 1'b0;
        end else begin
            standard_event_flags       <= next_esr;
            standard_event_enable_mask <= next_ese;
            status_enable_mask         <= next_sre;
            status_byte                <= sb_base | {1'b0, next_rqs, 6'h00};
            svc_prev                   <= svc;
        end
    end

    // Startup capture, power-on-clear setting and completion tracking
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            init_done   <= 1'b0;
            psc_setting <= 1'b0;
            opc_pending <= 1'b0;
        end else begin
            init_done   <= 1'b1;
            if (!init_done) begin
                psc_setting <= nv_psc;
            end else if (do_psc && psc_ok) begin
                psc_setting <= cmd_arg[0];
            end
            opc_pending <= do_opc || (opc_pending && !exec_idle && !do_cls);
        end
    end

    // Reply sequencer; a new command drops an unread reply
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= ccs_pkg::ccs_r_idle;
            is_idn      <= 1'b0;
            num_reg     <= 8'h00;
            idx         <= 6'h00;
            reply_valid <= 1'b0;
            reply_data  <= 8'h00;
            reply_last  <= 1'b0;
        end else if (take) begin
            reply_valid <= 1'b0;
            reply_last  <= 1'b0;
            is_idn      <= do_idnq;
            num_reg     <= q_num;
            if (do_opcq) begin
                state <= ccs_pkg::ccs_r_wait_opc;
            end else if (do_num || do_idnq) begin
                state <= ccs_pkg::ccs_r_load;
            end else begin
                state <= ccs_pkg::ccs_r_idle;
            end
        end else begin
            case (state)
                ccs_pkg::ccs_r_wait_opc: begin
                    if (exec_idle) begin
                        state <= ccs_pkg::ccs_r_load;
                    end
                end
                ccs_pkg::ccs_r_load: begin
                    state       <= ccs_pkg::ccs_r_send;
                    idx         <= 6'h00;
                    reply_valid <= 1'b1;
                    reply_data  <= pick_byte;
                    reply_last  <= pick_last;
                end
                ccs_pkg::ccs_r_send: begin
                    if (reply_ready && reply_last) begin
                        state       <= ccs_pkg::ccs_r_idle;
                        reply_valid <= 1'b0;
                        reply_last  <= 1'b0;
                    end else if (reply_ready) begin
                        idx        <= pick_idx;
                        reply_data <= pick_byte;
                        reply_last <= pick_last;
                    end
                end
                default: begin
                    state <= ccs_pkg::ccs_r_idle;
                end
            endcase
        end
    end

    // Saved-state slots
    ccs_slot_mem #(
        .DEPTH (`CCS_SLOTS),
        .W     (STATE_W)
    ) u_slots (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .wr_en      (save_valid && {4'h0, save_slot} <= `CCS_SLOT_MAX),
        .wr_addr    (save_slot),
        .wr_data    (save_state),
        .rd_en      (do_rcl && slot_ok),
        .rd_addr    (cmd_arg[3:0]),
        .rd_data    (mem_data),
        .rd_written (mem_written)
    );

    // Recall, reset and clear pulses to the instrument
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rcl_wait                  <= 1'b0;
            restore_valid             <= 1'b0;
            restore_state             <= '0;
            restore_default           <= 1'b0;
            defaults_load             <= 1'b0;
            trigger_abort             <= 1'b0;
            waiting_for_trigger_clear <= 1'b0;
            clear_events              <= 1'b0;
        end else begin
            rcl_wait      <= do_rcl && slot_ok;
            restore_valid <= rcl_wait;
            if (rcl_wait) begin
                restore_state   <= mem_written ? mem_data : DEFAULT_STATE;
                restore_default <= !mem_written;
            end
            defaults_load             <= do_rst;
            trigger_abort             <= do_rst;
            waiting_for_trigger_clear <= do_rst;
            clear_events              <= do_cls;
        end
    end

    default clocking ck @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence reply_pending_s;
        state != ccs_pkg::ccs_r_idle;
    endsequence
    sequence new_line_s;
        cmd_valid && init_done;
    endsequence

    cls_clears_a: assert property (do_cls && ev_set == 8'h00 |=> standard_event_flags == 8'h00 && !status_byte[`CCS_SB_RQS] && clear_events) else $error("clear status left bits set");
    ese_write_a: assert property (do_ese |=> standard_event_enable_mask == ($past(cmd_arg) & `CCS_EV_USED)) else $error("event mask write wrong");
    esb_summary_a: assert property (init_done |-> status_byte[`CCS_SB_ESB] == |(standard_event_flags & standard_event_enable_mask)) else $error("summary bit mismatch");
    unused_bits_a: assert property (!standard_event_flags[1] && !standard_event_flags[6] && !standard_event_enable_mask[1] && !standard_event_enable_mask[6]) else $error("unused bit set");
    esr_read_a: assert property (do_esrq && ev_set == 8'h00 |=> standard_event_flags == 8'h00 ##1 (reply_valid || $past(take))) else $error("event read did not clear or reply");
    opc_hold_a: assert property (do_opc && !opc_pending && !standard_event_flags[0] |=> !standard_event_flags[0]) else $error("completion bit set too early");
    opc_set_a: assert property (opc_pending && exec_idle |=> standard_event_flags[0]) else $error("completion bit not set");
    opcq_reply_a: assert property (state == ccs_pkg::ccs_r_wait_opc && exec_idle && !take ##1 !take |=> reply_valid && reply_data == 8'h31 && reply_last) else $error("completion reply wrong");
    qye_flag_a: assert property (reply_pending_s ##0 new_line_s |=> standard_event_flags[`CCS_EV_QYE]) else $error("query fault missed");
    rcl_range_a: assert property (do_rcl && !slot_ok |=> standard_event_flags[`CCS_EV_EXE] ##1 !restore_valid) else $error("bad slot not refused");
    rcl_empty_a: assert property (rcl_wait && !mem_written |=> restore_valid && restore_default && restore_state == DEFAULT_STATE) else $error("empty slot not defaulted");
    rst_abort_a: assert property (do_rst && !do_ese |=> defaults_load && trigger_abort && waiting_for_trigger_clear && $stable(standard_event_enable_mask)) else $error("reset side effects wrong");
    stb_keep_a: assert property (cmd_valid && init_done && cmd_code == ccs_pkg::ccs_cmd_stb_q && !serial_poll && status_byte[`CCS_SB_RQS] |=> status_byte[`CCS_SB_RQS]) else $error("status query cleared service bit");
endmodule // ccs_unit
`default_nettype wire

// ---- verification/ccs_host_model.sv ----
// Remote host model that takes reply bytes, stalling on request
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model (
    input  wire logic       core_clk,
    input  wire logic       stall,
    input  wire logic       reply_valid,
    input  wire logic [7:0] reply_data,
    input  wire logic       reply_last,
    output logic            reply_ready
);
    string text = "";
    int    replies = 0;
    bit    fin = 1'b1;
    initial reply_ready = 1'b0;
    // Collect bytes; a stalling host accepts every other cycle
    always @(posedge core_clk) begin
        if (reply_valid && reply_ready) begin
            text = $sformatf("%s%c", fin ? "" : text, reply_data);
            fin = reply_last;
            replies += int'(reply_last);
        end
        reply_ready <= !stall || !reply_ready;
    end
endmodule // ccs_host_model
`default_nettype wire

// ---- verification/ccs_unit_tb.sv ----
// Self-checking bench for the common command and status unit
`timescale 1ns/1ps
`default_nettype none
module ccs_unit_tb;
    logic core_clk = 0, rst_b = 0, cmd_valid = 0, exec_idle = 1, stall = 0;
    logic save_valid = 0, nv_psc = 0, serial_poll = 0;
    ccs_pkg::ccs_cmd_t cmd_code = ccs_pkg::ccs_cmd_cls;
    logic [7:0] cmd_arg = 8'h00, nv_ese = 8'h24;
    logic [4:0] ev = 5'h00;
    logic [3:0] save_slot = 4'h0;
    logic [31:0] save_state = 32'h0000_0000, restore_state;
    logic reply_valid, reply_ready, reply_last, psc_setting, clear_events;
    logic restore_valid, restore_default, defaults_load, trigger_abort, wtc;
    logic [7:0] reply_data, flags, emask, smask, stb;
    logic [7:0] wt [5] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h20};
    int errors = 0, check_count = 0;
    ccs_unit ccs_unit_i (.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .exec_idle(exec_idle),
        .query_fault_evt(ev[0]), .self_test_fail_evt(ev[1]), .cal_error_evt(ev[2]),
        .exec_fault_evt(ev[3]), .syntax_fault_evt(ev[4]), .serial_poll(serial_poll),
        .stb_other(8'h00), .nv_psc(nv_psc), .nv_ese(nv_ese), .nv_sre(nv_ese),
        .ctl_rev(12'h123), .fp_rev(12'h456), .mb_rev(12'h789), .save_valid(save_valid),
        .save_slot(save_slot), .save_state(save_state), .reply_ready(reply_ready),
        .reply_valid(reply_valid), .reply_data(reply_data), .reply_last(reply_last),
        .standard_event_flags(flags), .standard_event_enable_mask(emask),
        .status_enable_mask(smask), .status_byte(stb), .psc_setting(psc_setting),
        .clear_events(clear_events), .restore_valid(restore_valid),
        .restore_state(restore_state), .restore_default(restore_default),
        .defaults_load(defaults_load), .trigger_abort(trigger_abort),
        .waiting_for_trigger_clear(wtc));
    ccs_host_model host_i (.core_clk(core_clk), .stall(stall), .reply_valid(reply_valid),
        .reply_data(reply_data), .reply_last(reply_last), .reply_ready(reply_ready));
    // Clock, compare and bus-cycle helpers
    initial forever #5 core_clk = ~core_clk;
    task automatic summarize;
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic chks(string n, string e, string g);
        check_count++;
        if (g != e) begin
            errors++;
            $display("BAD %s exp %s got %s", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic cmd(ccs_pkg::ccs_cmd_t c, logic [7:0] a);
        cmd_code = c;
        cmd_arg = a;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
    endtask
    task automatic query(ccs_pkg::ccs_cmd_t c, string e);
        int r;
        cyc(1);
        r = host_i.replies;
        cmd(c, 8'h00);
        for (int i = 0; i < 200 && host_i.replies == r; i++) cyc(1);
        if (host_i.replies == r) begin
            errors++;
            summarize();
        end
        chks("reply", e, host_i.text);
    endtask
    task automatic rcl(logic [7:0] s, logic d, logic [31:0] v);
        cmd(ccs_pkg::ccs_cmd_rcl, s);
        for (int i = 0; i < 10 && !restore_valid; i++) cyc(1);
        chk("restore_valid", 1'b1, restore_valid);
        chk("restore_default", d, restore_default);
        chk("restore_state", v, restore_state);
    endtask
    task automatic rst(logic p, logic [7:0] m);
        nv_psc = p;
        nv_ese = m;
        rst_b = 1'b0;
        cyc(6);
        rst_b = 1'b1;
        cyc(2);
    endtask
    // Main sequence
    initial begin
        rst(1'b0, 8'h24);
        chk("flags", 8'h80, flags);
        chk("emask", 8'h24, emask);
        chk("smask", 8'h24, smask);
        query(ccs_pkg::ccs_cmd_esr_q, "128");
        chk("flags", 8'h00, flags);
        cmd(ccs_pkg::ccs_cmd_ese, 8'hFF);
        chk("emask", 8'hBD, emask);
        query(ccs_pkg::ccs_cmd_ese_q, "189");
        cmd(ccs_pkg::ccs_cmd_sre, 8'h20);
        for (int i = 0; i < 5; i++) begin
            ev = 5'h01 << i;
            cyc(1);
            ev = 5'h00;
            cyc(1);
            chk("summary", 1'b1, stb[5]);
            query(ccs_pkg::ccs_cmd_esr_q, $sformatf("%0d", wt[i]));
        end
        serial_poll = 1'b1;
        cyc(1);
        serial_poll = 1'b0;
        chk("rqs", 1'b0, stb[6]);
        cmd_code = ccs_pkg::ccs_cmd_sre_q;
        cmd_valid = 1'b1;
        cyc(1);
        cmd(ccs_pkg::ccs_cmd_ese, 8'hBD);
        chk("qye", 1'b1, flags[2]);
        chk("reply_valid", 1'b0, reply_valid);
        ev = 5'h08;
        cyc(1);
        ev = 5'h00;
        cyc(2);
        query(ccs_pkg::ccs_cmd_stb_q, "96");
        chk("rqs", 1'b1, stb[6]);
        cmd(ccs_pkg::ccs_cmd_cls, 8'h00);
        chk("clear_events", 1'b1, clear_events);
        cyc(1);
        chk("flags", 8'h00, flags);
        chk("stb", 8'h00, stb);
        exec_idle = 1'b0;
        cmd(ccs_pkg::ccs_cmd_opc, 8'h00);
        cyc(4);
        chk("opc", 1'b0, flags[0]);
        exec_idle = 1'b1;
        cyc(3);
        chk("opc", 1'b1, flags[0]);
        exec_idle = 1'b0;
        fork
            begin
                cyc(6);
                exec_idle = 1'b1;
            end
        join_none
        query(ccs_pkg::ccs_cmd_opc_q, "1");
        cmd(ccs_pkg::ccs_cmd_psc, 8'h01);
        chk("psc", 1'b1, psc_setting);
        query(ccs_pkg::ccs_cmd_psc_q, "1");
        cmd(ccs_pkg::ccs_cmd_psc, 8'h02);
        query(ccs_pkg::ccs_cmd_esr_q, "17");
        save_slot = 4'h3;
        save_state = 32'hA5A5_0003;
        save_valid = 1'b1;
        cyc(1);
        save_valid = 1'b0;
        rcl(8'h03, 1'b0, 32'hA5A5_0003);
        rcl(8'h05, 1'b1, 32'h0000_0000);
        cmd(ccs_pkg::ccs_cmd_rcl, 8'h0A);
        query(ccs_pkg::ccs_cmd_esr_q, "16");
        ev = 5'h10;
        cyc(1);
        ev = 5'h00;
        cmd(ccs_pkg::ccs_cmd_rst, 8'h00);
        chk("reset", 3'b111, {defaults_load, trigger_abort, wtc});
        chk("flags", 8'h20, flags);
        chk("emask", 8'hBD, emask);
        stall = 1'b1;
        query(ccs_pkg::ccs_cmd_idn_q,
            "ACMELABS,PSU-0002,SN000001,1.2.3-4.5.6-7.8.9");
        stall = 1'b0;
        rst(1'b1, 8'hFF);
        chk("emask", 8'h00, emask);
        chk("smask", 8'h00, smask);
        summarize();
    end
endmodule // ccs_unit_tb
`default_nettype wire
